// [core/uhrm_defines.vh]
`ifndef UHRM_DEFINES_VH
`define UHRM_DEFINES_VH
// command codes (read code; write code is read code with the write flag set)
`define UHRM_WRITE_FLAG_BIT      7
`define UHRM_CMD_HC_VERSION      7'h00
`define UHRM_CMD_HC_OPER_CTRL    7'h01
`define UHRM_CMD_HC_CMD_STATE    7'h02
`define UHRM_CMD_HC_IRQ_FLAGS    7'h03
`define UHRM_CMD_HC_IRQ_MSET     7'h04
`define UHRM_CMD_HC_IRQ_MCLR     7'h05
`define UHRM_CMD_FRAME_INTERVAL  7'h0d
`define UHRM_CMD_FRAME_LEFT      7'h0e
`define UHRM_CMD_FRAME_COUNT     7'h0f
`define UHRM_CMD_LS_CUTOFF       7'h11
`define UHRM_CMD_RH_DESC_A       7'h12
`define UHRM_CMD_RH_DESC_B       7'h13
`define UHRM_CMD_RH_STATE        7'h14
`define UHRM_CMD_PORT1_STATE     7'h15
`define UHRM_CMD_PORT2_STATE     7'h16
`define UHRM_CMD_PER_DONE_MAP    7'h17
`define UHRM_CMD_PER_SKIP_MAP    7'h18
`define UHRM_CMD_PER_LAST        7'h19
`define UHRM_CMD_PER_ACTIVE      7'h1a
`define UHRM_CMD_ASY_DONE_MAP    7'h1b
`define UHRM_CMD_ASY_SKIP_MAP    7'h1c
`define UHRM_CMD_ASY_LAST        7'h1d
`define UHRM_CMD_ASY_ACTIVE      7'h1e
`define UHRM_CMD_HW_SETUP        7'h20
`define UHRM_CMD_DMA_SETUP       7'h21
`define UHRM_CMD_XFER_LEN        7'h22
`define UHRM_CMD_CPU_IRQ_FLAGS   7'h24
`define UHRM_CMD_CPU_IRQ_MASK    7'h25
`define UHRM_CMD_PART_ID         7'h27
`define UHRM_CMD_SCRATCH         7'h28
`define UHRM_CMD_SOFT_RESET      7'h29
`define UHRM_CMD_BUF_FILL        7'h2c
`define UHRM_CMD_ISO_BUF_SIZE    7'h30
`define UHRM_CMD_DIRECT_ADDR_LEN 7'h32
`define UHRM_CMD_PER_BUF_SIZE    7'h33
`define UHRM_CMD_ASY_BUF_SIZE    7'h34
`define UHRM_CMD_ISO0_PORT       7'h40
`define UHRM_CMD_ISO1_PORT       7'h42
`define UHRM_CMD_PER_PORT        7'h43
`define UHRM_CMD_ASY_PORT        7'h44
`define UHRM_CMD_DIRECT_DATA     7'h45
`define UHRM_CMD_ISO_TOGGLE      7'h47
`define UHRM_CMD_ASY_DONE_CNT    7'h51
`define UHRM_CMD_ASY_DONE_TMO    7'h52
`define UHRM_CMD_PER_BLK_SIZE    7'h53
`define UHRM_CMD_ASY_BLK_SIZE    7'h54
// reset values
`define UHRM_RST_WORD            32'h0000_0000
`define UHRM_SOFT_RESET_KEY      16'h00f6
`endif

// [core/uhrm_register_map.v]
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "uhrm_defines.vh"

module uhrm_register_map #(
    parameter [15:0] PART_ID_VALUE  = 16'h0a5a, // arbitrary neutral value
    parameter [31:0] REVISION_VALUE = 32'h0000_0010, // arbitrary neutral value
    parameter [15:0] RESET_KEY      = `UHRM_SOFT_RESET_KEY
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [7:0]  cmd_addr,
    input  wire [31:0] wr_data,
    input  wire        wr_strobe,
    input  wire        rd_strobe,
    input  wire [31:0] periodic_done_in,
    input  wire [31:0] async_done_in,
    input  wire [15:0] periodic_active_in,
    input  wire [15:0] async_active_in,
    output reg  [31:0] rd_data,
    output reg         soft_reset_pulse
);

    // storage for every writable register, indexed by read code
    reg  [31:0] regs_reg [0:127];
    reg  [31:0] rd_next;
    wire [6:0]  idx;
    wire        write_cmd;
    integer     i;

    assign idx       = cmd_addr[6:0];
    assign write_cmd = cmd_addr[`UHRM_WRITE_FLAG_BIT];

    // auxiliary registers (20h and up) except 32h keep only 16 bits, the rest is dropped on write
    function is_narrow;
        input [6:0] a;
        begin
            is_narrow = (a >= `UHRM_CMD_HW_SETUP) && (a != `UHRM_CMD_DIRECT_ADDR_LEN);
        end
    endfunction

    // true for codes that store writes; read-only codes and the soft reset command (29h) are absent here
    function is_writable;
        input [6:0] a;
        begin
            case (a)
                `UHRM_CMD_HC_OPER_CTRL, `UHRM_CMD_HC_CMD_STATE, `UHRM_CMD_HC_IRQ_FLAGS,
                `UHRM_CMD_HC_IRQ_MSET, `UHRM_CMD_HC_IRQ_MCLR, `UHRM_CMD_FRAME_INTERVAL,
                `UHRM_CMD_FRAME_LEFT, `UHRM_CMD_FRAME_COUNT, `UHRM_CMD_LS_CUTOFF,
                `UHRM_CMD_RH_DESC_A, `UHRM_CMD_RH_DESC_B, `UHRM_CMD_RH_STATE,
                `UHRM_CMD_PORT1_STATE, `UHRM_CMD_PORT2_STATE, `UHRM_CMD_PER_SKIP_MAP,
                `UHRM_CMD_PER_LAST, `UHRM_CMD_ASY_SKIP_MAP, `UHRM_CMD_ASY_LAST,
                `UHRM_CMD_HW_SETUP, `UHRM_CMD_DMA_SETUP, `UHRM_CMD_XFER_LEN,
                `UHRM_CMD_CPU_IRQ_FLAGS, `UHRM_CMD_CPU_IRQ_MASK, `UHRM_CMD_SCRATCH,
                `UHRM_CMD_BUF_FILL, `UHRM_CMD_ISO_BUF_SIZE, `UHRM_CMD_DIRECT_ADDR_LEN,
                `UHRM_CMD_PER_BUF_SIZE, `UHRM_CMD_ASY_BUF_SIZE, `UHRM_CMD_ISO0_PORT,
                `UHRM_CMD_ISO1_PORT, `UHRM_CMD_PER_PORT, `UHRM_CMD_ASY_PORT,
                `UHRM_CMD_DIRECT_DATA, `UHRM_CMD_ISO_TOGGLE, `UHRM_CMD_ASY_DONE_CNT,
                `UHRM_CMD_ASY_DONE_TMO, `UHRM_CMD_PER_BLK_SIZE, `UHRM_CMD_ASY_BLK_SIZE:
                    is_writable = 1'b1;
                default:
                    is_writable = 1'b0;
            endcase
        end
    endfunction

    // write path; storage is flat so the map mirrors the standard offsets
    always @(posedge clk) begin
        if (sys_rst) begin
            for (i = 0; i < 128; i = i + 1) begin
                regs_reg[i] <= `UHRM_RST_WORD;
            end
        end else if (wr_strobe && write_cmd && is_writable(idx)) begin
            if (is_narrow(idx)) begin
                regs_reg[idx] <= {16'h0000, wr_data[15:0]};
            end else begin
                regs_reg[idx] <= wr_data;
            end
        end
    end

    // software reset command: one pulse when the key word is written
    always @(posedge clk) begin
        if (sys_rst) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= wr_strobe && write_cmd &&
                                (idx == `UHRM_CMD_SOFT_RESET) && (wr_data[15:0] == RESET_KEY);
        end
    end

    // read mux; status registers show live hardware state, not storage
    always @* begin
        rd_next = 32'h0000_0000;
        if (!write_cmd) begin
            case (idx)
                `UHRM_CMD_HC_VERSION:   rd_next = REVISION_VALUE;
                `UHRM_CMD_PER_DONE_MAP: rd_next = periodic_done_in;
                `UHRM_CMD_ASY_DONE_MAP: rd_next = async_done_in;
                `UHRM_CMD_PER_ACTIVE:   rd_next = {16'h0000, periodic_active_in};
                `UHRM_CMD_ASY_ACTIVE:   rd_next = {16'h0000, async_active_in};
                `UHRM_CMD_PART_ID:      rd_next = {16'h0000, PART_ID_VALUE};
                default: begin
                    if (is_writable(idx)) begin
                        rd_next = regs_reg[idx];
                    end
                end
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= 32'h0000_0000;
        end else if (rd_strobe) begin
            rd_data <= rd_next;
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end

endmodule // uhrm_register_map

// [verif/uhrm_checker.sv]
`timescale 1ns/1ps
// port watcher; expected figures are the design defaults
module uhrm_checker (
    input wire        clk,
    input wire        sys_rst,
    input wire [7:0]  cmd_addr,
    input wire [31:0] wr_data,
    input wire        wr_strobe,
    input wire        rd_strobe,
    input wire [31:0] periodic_done_in,
    input wire [31:0] async_done_in,
    input wire [15:0] periodic_active_in,
    input wire [15:0] async_active_in,
    input wire [31:0] rd_data,
    input wire        soft_reset_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_rd_idle_zero: assert property (!$past(rd_strobe) |-> rd_data == 32'h0000_0000)
        else $error("read data not idle");
    a_pulse_cause: assert property (soft_reset_pulse |-> $past(wr_strobe && cmd_addr == 8'ha9))
        else $error("reset pulse without write");
    a_key_fires: assert property (wr_strobe && cmd_addr == 8'ha9 && wr_data[15:0] == 16'h00f6
        |=> soft_reset_pulse) else $error("reset pulse missing");
    a_ver_read: assert property (rd_strobe && cmd_addr == 8'h00 |=> rd_data == 32'h0000_0010)
        else $error("version wrong");
    a_done_live: assert property (rd_strobe && cmd_addr == 8'h1b |=> rd_data == $past(async_done_in))
        else $error("done map wrong");
    a_active_pad: assert property (rd_strobe && cmd_addr == 8'h1e
        |=> rd_data == {16'h0000, $past(async_active_in)}) else $error("active entry wrong");
    a_flag_read: assert property (rd_strobe && (cmd_addr[7] || cmd_addr == 8'h29)
        |=> rd_data == 32'h0000_0000) else $error("bad code read not zero");
    a_scratch_echo: assert property (wr_strobe && cmd_addr == 8'ha8 ##1 rd_strobe && cmd_addr == 8'h28
        |=> rd_data == ($past(wr_data, 2) & 32'h0000_ffff)) else $error("scratch echo");
endmodule // uhrm_checker

// [verif/uhrm_host_model.sv]
`timescale 1ns/1ps
// driver cpu; a write leaves its strobe up and a read drops both, so calls run back to back
module uhrm_host_model (
    input  wire        clk,
    output reg  [7:0]  cmd_addr,
    output reg  [31:0] wr_data,
    output reg         wr_strobe,
    output reg         rd_strobe,
    input  wire [31:0] rd_data
);
    initial {cmd_addr, wr_data, wr_strobe, rd_strobe} = 42'h0;
    task wr(input [7:0] c, input [31:0] d);
        @(posedge clk);
        {cmd_addr, wr_data, wr_strobe, rd_strobe} <= {c, d, 2'b10};
    endtask
    // data taken in its one cycle; bus scrambled after so nothing stale lingers
    task rd(input [7:0] c, output [31:0] q);
        @(posedge clk);
        {cmd_addr, wr_strobe, rd_strobe} <= {c, 2'b01};
        @(posedge clk);
        {cmd_addr, wr_data, wr_strobe, rd_strobe} <= {8'h7f, ~wr_data, 2'b00};
        #1 q = rd_data;
    endtask
endmodule // uhrm_host_model

// [verif/usb_host_ctrl_register_map_tb_top.sv]
`timescale 1ns/1ps
module usb_host_ctrl_register_map_tb_top;
    reg clk = 0, sys_rst = 1;
    reg [31:0] pd = 0, ad = 0, got, shadow [0:127];
    reg [15:0] pa = 0, aa = 0;
    wire [7:0] cmd_addr;
    wire [31:0] wr_data, rd_data;
    wire wr_strobe, rd_strobe, soft_reset_pulse;
    integer error_cnt = 0, total_checks = 0, cyc = 0, seed = 32'hacc9, i;
    reg [7:0] rw [0:38] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0d, 8'h0e, 8'h0f, 8'h11, 8'h12,
        8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1c, 8'h1d, 8'h20, 8'h21, 8'h22, 8'h24, 8'h25,
        8'h28, 8'h2c, 8'h30, 8'h32, 8'h33, 8'h34, 8'h40, 8'h42, 8'h43, 8'h44, 8'h45, 8'h47, 8'h51,
        8'h52, 8'h53, 8'h54};
    reg [7:0] ro [0:8] = '{8'h00, 8'h17, 8'h1a, 8'h1b, 8'h1e, 8'h27, 8'h29, 8'h7f, 8'hff};
    always #12.5 clk = ~clk;
    uhrm_host_model hm_u (.clk(clk), .cmd_addr(cmd_addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data));
    uhrm_register_map dut_u (.clk(clk), .sys_rst(sys_rst), .cmd_addr(cmd_addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .periodic_done_in(pd), .async_done_in(ad),
        .periodic_active_in(pa), .async_active_in(aa), .rd_data(rd_data),
        .soft_reset_pulse(soft_reset_pulse));
    // codes below 20h and 32h keep all 32 bits
    function [31:0] mask(input [7:0] c);
        mask = (c < 8'h20 || c == 8'h32) ? 32'hffff_ffff : 32'h0000_ffff;
    endfunction
    function [31:0] ro_exp(input [7:0] c);
        case (c)
            8'h00: ro_exp = 32'h0000_0010;
            8'h17: ro_exp = pd;
            8'h1a: ro_exp = {16'h0000, pa};
            8'h1b: ro_exp = ad;
            8'h1e: ro_exp = {16'h0000, aa};
            8'h27: ro_exp = 32'h0000_0a5a;
            default: ro_exp = 32'h0000_0000;
        endcase
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        total_checks = total_checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task tally_and_finish;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 0;
        for (i = 0; i < 39; i = i + 1) begin
            got = $random(seed);
            shadow[rw[i]] = got & mask(rw[i]);
            hm_u.wr(rw[i] | 8'h80, got & mask(rw[i]));
        end
        for (i = 0; i < 39; i = i + 1) begin
            hm_u.rd(rw[i], got);
            chk(got, shadow[rw[i]]);
        end
        hm_u.rd(8'h01, got);
        hm_u.wr(8'h81, got ^ 32'h0000_0400);
        hm_u.wr(8'ha8, 32'hbeef_5a3c);
        hm_u.rd(8'h28, got);
        chk(got, 32'h0000_5a3c);
        hm_u.rd(8'h01, got);
        chk(got, shadow[1] ^ 32'h0000_0400);
        @(posedge clk) {pd, ad, pa, aa} <= {$random(seed), $random(seed), $random(seed)};
        hm_u.wr(8'ha9, 32'hffff_00f5);
        for (i = 0; i < 9; i = i + 1) begin
            if (ro[i] != 8'h29) hm_u.wr(ro[i] | 8'h80, $random(seed));
            hm_u.rd(ro[i], got);
            chk(got, ro_exp(ro[i]));
        end
        hm_u.wr(8'ha9, 32'h0000_00f6);
        hm_u.rd(8'h7f, got);
        tally_and_finish;
    end
endmodule // usb_host_ctrl_register_map_tb_top
bind uhrm_register_map uhrm_checker chk_u (.clk(clk), .sys_rst(sys_rst), .cmd_addr(cmd_addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .periodic_done_in(periodic_done_in), .async_done_in(async_done_in),
    .periodic_active_in(periodic_active_in), .async_active_in(async_active_in),
    .rd_data(rd_data), .soft_reset_pulse(soft_reset_pulse));
